// ===== include/alarm_pkg.sv
/*
 * Shared constants and types for the temperature alarm block:
 * register pointers, reset values, setup fields and timing.
 * Assumes a 40 MHz system clock.
 */
package alarm_pkg;

    // Register pointers.
    localparam logic [7:0]  PTR_AMBIENT = 8'h00;
    localparam logic [7:0]  PTR_SETUP   = 8'h01;
    localparam logic [7:0]  PTR_LOWER   = 8'h02;
    localparam logic [7:0]  PTR_UPPER   = 8'h03;

    // Reset values.
    localparam logic [15:0] AMBIENT_RST = 16'h0000;
    // Limits power up at 75 and 80 degrees in the 9-bit signed layout.
    localparam logic [15:0] LOWER_RST   = 16'h4b00;
    localparam logic [15:0] UPPER_RST   = 16'h5000;
    localparam logic [7:0]  SETUP_RST   = 8'h00;

    // Setup field positions.
    localparam int B_SHDN  = 0;
    localparam int B_STYLE = 1;
    localparam int B_POL   = 2;
    localparam int B_FQ    = 3;
    localparam int B_RES   = 5;
    localparam int B_ONE   = 7;

    // Limits keep bits 15..7; the rest read as zero.
    localparam int          LIM_LSB   = 7;
    localparam logic [11:0] FINE_BITS = 12'h007;
    localparam logic [2:0]  CNT_MAX   = 3'h7;
    localparam logic [2:0]  FQ_CNT [4] = '{3'h1, 3'h2, 3'h4, 3'h6};

    // Conversion time at the coarsest resolution, and clock rate.
    localparam int CONV_MS = 30;
    localparam int CLK_KHZ = 40000;
    localparam int TMR_W   = 24;

    typedef enum {CV_IDLE, CV_RUN} conv_t;
    typedef enum {LK_IDLE, LK_ADDR, LK_PTR, LK_WDAT, LK_RDAT} link_t;

endpackage : alarm_pkg

// ===== hdl/temp_alarm.sv
/*
 * Temperature alarm and conversion mode controller with its
 * two-wire register port. Assumes the measurement front end
 * presents a 12-bit reading on temp_in in the clk domain, and
 * the serial clock scl_in runs only during frames.
 */
// Functional notes
// - Upper limit at pointer 3, 9-bit signed, bits 6..0 read zero.
// - Shutdown stops sampling; the serial port keeps working.
// - All four registers stay readable and writable in shutdown.
// - Single-measure performs one conversion then returns to shutdown.
// - End of single conversion updates ambient and clears setup bit 7.
// - Setup bits 7,0 decode continuous, shutdown, ignored, single.
// - One conversion lasts the conversion time of the resolution.
// - Bit 1 picks comparator or interrupt, bit 2 polarity.
// - Comparator asserts above upper, holds until below lower.
// - Comparator alarm holds in shutdown; clears only while converting.
// - Interrupt asserts above upper, clears on any register read.
// - Interrupt asserts again below lower, cleared by a read.
// - Entering shutdown clears the interrupt style alarm.
// - Alarm needs the chosen count of consecutive high conversions.
// - Same count applies to the lower limit.
// - Bits 6..5 pick 9 to 12 bit resolution.
// - Fault count codes mean 1, 2, 4, 6; reset 00.
// - Style bit 0 comparator (reset), 1 interrupt.
// - Polarity bit 0 active low (reset), 1 active high.
`timescale 1ns/10ps
module temp_alarm
    import alarm_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h2a, // Arbitrary value.
    parameter int         CONV_CYC = CONV_MS * CLK_KHZ
)(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    input  wire logic [11:0] temp_in,
    output logic             sda_out,
    output logic             sda_oe_n,
    output logic             alert_out
);

    if (CONV_CYC < 1 || CONV_CYC > (2 ** (TMR_W - 3)) - 1)
    begin : g_chk
        $error("CONV_CYC does not fit the conversion timer");
    end

    // ************************************************************
    // Link side, clocked by the serial clock
    // ************************************************************
    link_t       lk_q;
    logic [3:0]  bcnt_q;
    logic [7:0]  sh_q, ptr_q, wr_byte_q, wr_ptr_q;
    logic        wr_idx_q, bsel_q, ack_q, rw_q;
    logic        wr_tog_q, rd_tog_q, rq_tog_q;
    logic        st_q, st_ack_q, st_clr, drv_q;
    logic [15:0] tx_q;
    logic [7:0]  byte_in;
    logic [15:0] rd_word_q;

    assign byte_in = {sh_q[6:0], sda_in};
    assign st_clr  = sys_rst | st_ack_q;

    // Start detector: sda falling while scl is high. The link clock
    // is idle at reset, so link flops clear without it.
    always_ff @(negedge sda_in or posedge st_clr)
    begin
        if (st_clr)
            st_q <= 1'b0;
        else if (scl_in)
            st_q <= 1'b1;
    end

    // Bit and byte sequencing on each rising serial clock edge.
    always_ff @(posedge scl_in or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            lk_q <= LK_IDLE;
            bcnt_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= PTR_AMBIENT;
            wr_byte_q <= 8'h00;
            wr_ptr_q <= 8'h00;
            wr_idx_q <= 1'b0;
            bsel_q <= 1'b0;
            ack_q <= 1'b0;
            rw_q <= 1'b0;
            wr_tog_q <= 1'b0;
            rd_tog_q <= 1'b0;
            rq_tog_q <= 1'b0;
            st_ack_q <= 1'b0;
            tx_q <= 16'h0000;
        end
        else
        begin
            st_ack_q <= st_q;
            if (st_q)
            begin
                lk_q <= LK_ADDR;
                bcnt_q <= 4'h1;
                sh_q <= byte_in;
                rq_tog_q <= ~rq_tog_q; // Snapshot the pointed word.
            end
            else if (lk_q != LK_IDLE && bcnt_q < 4'h7)
            begin
                sh_q <= byte_in;
                bcnt_q <= bcnt_q + 4'h1;
            end
            else if (lk_q != LK_IDLE && bcnt_q == 4'h7)
            begin
                bcnt_q <= 4'h8;
                sh_q <= byte_in;
                ack_q <= (lk_q != LK_RDAT);
                case (lk_q)
                    LK_ADDR:
                    begin
                        ack_q <= (byte_in[7:1] == DEV_ADDR);
                        rw_q <= byte_in[0];
                    end
                    LK_PTR: ptr_q <= byte_in;
                    LK_WDAT:
                    begin
                        wr_byte_q <= byte_in;
                        wr_ptr_q <= ptr_q;
                        wr_idx_q <= bsel_q;
                        wr_tog_q <= ~wr_tog_q;
                        bsel_q <= 1'b1;
                    end
                    default: ;
                endcase
            end
            else if (lk_q != LK_IDLE)
            begin
                bcnt_q <= 4'h0;
                case (lk_q)
                    LK_ADDR:
                    begin
                        bsel_q <= 1'b0;
                        if (!ack_q)
                            lk_q <= LK_IDLE;
                        else if (rw_q)
                        begin
                            lk_q <= LK_RDAT;
                            tx_q <= rd_word_q;
                            rd_tog_q <= ~rd_tog_q;
                        end
                        else
                            lk_q <= LK_PTR;
                    end
                    LK_PTR: lk_q <= LK_WDAT;
                    LK_RDAT:
                    begin
                        bsel_q <= ~bsel_q;
                        if (sda_in)
                            lk_q <= LK_IDLE; // Host refused more data.
                    end
                    default: ;
                endcase
            end
        end
    end

    // Drive the data line while scl is low: acks and read bits.
    always_ff @(negedge scl_in or posedge sys_rst)
    begin
        if (sys_rst)
            drv_q <= 1'b0;
        else
            drv_q <= (lk_q != LK_IDLE && lk_q != LK_RDAT
                      && bcnt_q == 4'h8 && ack_q)
                  || (lk_q == LK_RDAT && bcnt_q != 4'h8
                      && !tx_q[~{bsel_q, bcnt_q[2:0]}]);
    end

    assign sda_out  = 1'b0;
    assign sda_oe_n = ~drv_q;

    // ************************************************************
    // Crossing into the system clock
    // ************************************************************
    logic [2:0] wr_s_q, rd_s_q, rq_s_q;
    logic       wr_evt, rd_evt, rq_evt;

    // Toggles pass two flops; the third flop only finds the edge.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            wr_s_q <= 3'h0;
            rd_s_q <= 3'h0;
            rq_s_q <= 3'h0;
        end
        else
        begin
            wr_s_q <= {wr_s_q[1:0], wr_tog_q};
            rd_s_q <= {rd_s_q[1:0], rd_tog_q};
            rq_s_q <= {rq_s_q[1:0], rq_tog_q};
        end
    end

    assign wr_evt = wr_s_q[2] ^ wr_s_q[1];
    assign rd_evt = rd_s_q[2] ^ rd_s_q[1];
    assign rq_evt = rq_s_q[2] ^ rq_s_q[1];

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0]  setup_q;
    logic [15:0] ambient_q, lower_q, upper_q, amb_new;
    logic        wr_setup, os_go, run_cont, cv_end, single_q;
    logic [1:0]  res;

    assign wr_setup = wr_evt && wr_ptr_q == PTR_SETUP && !wr_idx_q;
    assign run_cont = !setup_q[B_SHDN];
    assign res      = setup_q[B_RES +: 2];
    // Single measure only counts when shutdown was already set.
    assign os_go    = wr_setup && wr_byte_q[B_ONE]
                   && wr_byte_q[B_SHDN] && setup_q[B_SHDN];
    assign amb_new  = {temp_in & ~(FINE_BITS >> res), 4'h0};

    // Setup register; the host write lands after the self clear.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            setup_q <= SETUP_RST;
        else
        begin
            if (cv_end && single_q)
                setup_q[B_ONE] <= 1'b0;
            if (wr_setup)
                setup_q <= wr_byte_q;
        end
    end

    // Limits and reading; the host may write all of them.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            ambient_q <= AMBIENT_RST;
            lower_q <= LOWER_RST;
            upper_q <= UPPER_RST;
        end
        else
        begin
            if (cv_end)
                ambient_q <= amb_new;
            if (wr_evt && !wr_idx_q)
                case (wr_ptr_q)
                    PTR_AMBIENT: ambient_q[15:8] <= wr_byte_q;
                    PTR_LOWER:   lower_q[15:8] <= wr_byte_q;
                    PTR_UPPER:   upper_q[15:8] <= wr_byte_q;
                    default: ;
                endcase
            if (wr_evt && wr_idx_q)
                case (wr_ptr_q)
                    PTR_AMBIENT: ambient_q[7:0] <= wr_byte_q;
                    PTR_LOWER:   lower_q[LIM_LSB] <= wr_byte_q[7];
                    PTR_UPPER:   upper_q[LIM_LSB] <= wr_byte_q[7];
                    default: ;
                endcase
        end
    end

    // Word snapshot for the link, held until the next frame start.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            rd_word_q <= 16'h0000;
        else if (rq_evt)
            case (ptr_q)
                PTR_AMBIENT: rd_word_q <= ambient_q;
                PTR_SETUP:   rd_word_q <= {setup_q, 8'h00};
                PTR_LOWER:   rd_word_q <= lower_q;
                PTR_UPPER:   rd_word_q <= upper_q;
                default:     rd_word_q <= 16'h0000;
            endcase
    end

    // ************************************************************
    // Conversion timing
    // ************************************************************
    conv_t            cv_q;
    logic [TMR_W-1:0] tmr_q, conv_len;

    assign conv_len = TMR_W'(CONV_CYC) << res;
    assign cv_end   = cv_q == CV_RUN && tmr_q == conv_len - 1'b1
                   && (run_cont || single_q);

    // Shutdown aborts a running continuous conversion.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            cv_q <= CV_IDLE;
            tmr_q <= '0;
            single_q <= 1'b0;
        end
        else
            case (cv_q)
                CV_IDLE:
                    if (run_cont || os_go)
                    begin
                        cv_q <= CV_RUN;
                        tmr_q <= '0;
                        single_q <= os_go;
                    end
                CV_RUN:
                    if (!run_cont && !single_q)
                        cv_q <= CV_IDLE;
                    else if (cv_end)
                    begin
                        tmr_q <= '0;
                        single_q <= 1'b0;
                        if (single_q)
                            cv_q <= CV_IDLE;
                    end
                    else
                        tmr_q <= tmr_q + 1'b1;
                default: cv_q <= CV_IDLE;
            endcase
    end

    // ************************************************************
    // Fault queue and alarm
    // ************************************************************
    logic [2:0] hi_q, lo_q, hi_n, lo_n, need;
    logic       above, below, alarm_q, want_hi_q, istyle, shdn_on;

    assign above  = $signed(amb_new) > $signed(upper_q);
    assign below  = $signed(amb_new) < $signed(lower_q);
    assign need   = FQ_CNT[setup_q[B_FQ +: 2]];
    assign hi_n   = !above ? 3'h0 : (hi_q == CNT_MAX ? hi_q : hi_q + 3'h1);
    assign lo_n   = !below ? 3'h0 : (lo_q == CNT_MAX ? lo_q : lo_q + 3'h1);
    assign istyle = setup_q[B_STYLE];
    assign shdn_on = wr_setup && wr_byte_q[B_SHDN] && run_cont;

    // Consecutive counts advance at each finished conversion.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            hi_q <= 3'h0;
            lo_q <= 3'h0;
        end
        else if (cv_end)
        begin
            hi_q <= hi_n;
            lo_q <= lo_n;
        end
    end

    // Alarm state; a new event wins over a read in the same cycle.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            alarm_q <= 1'b0;
            want_hi_q <= 1'b1;
        end
        else if (istyle)
        begin
            if (rd_evt || shdn_on)
                alarm_q <= 1'b0;
            if (cv_end && want_hi_q && hi_n == need)
            begin
                alarm_q <= 1'b1;
                want_hi_q <= 1'b0;
            end
            else if (cv_end && !want_hi_q && lo_n == need)
            begin
                alarm_q <= 1'b1;
                want_hi_q <= 1'b1;
            end
        end
        else
        begin
            want_hi_q <= 1'b1;
            if (cv_end && hi_n >= need)
                alarm_q <= 1'b1;
            else if (cv_end && run_cont && lo_n >= need)
                alarm_q <= 1'b0;
        end
    end

    // Pin level follows polarity; reset leaves an active-low idle.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            alert_out <= 1'b1;
        else
            alert_out <= alarm_q ^ ~setup_q[B_POL];
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_UPPER_LOW: assert property (upper_q[6:0] == 7'h00)
        else $error("upper limit low bits not zero");
    AST_SHDN_IDLE: assert property (cv_q == CV_IDLE && !run_cont
        && !os_go |=> cv_q == CV_IDLE)
        else $error("conversion started in shutdown");
    AST_OS_START: assert property (os_go |=> cv_q == CV_RUN
        && single_q && tmr_q == '0)
        else $error("single measure did not start");
    AST_OS_END: assert property (cv_end && single_q && !wr_setup
        |=> cv_q == CV_IDLE && !setup_q[B_ONE]
        && ambient_q == $past(amb_new))
        else $error("single measure did not finish cleanly");
    AST_CONV_LEN: assert property ($rose(cv_q == CV_RUN) ##1
        (cv_q == CV_RUN && !cv_end) [*2] |-> tmr_q == 2)
        else $error("conversion timer not counting");
    AST_INT_RD: assert property (istyle && rd_evt && !cv_end
        |=> !alarm_q)
        else $error("read did not clear interrupt");
    AST_INT_SHDN: assert property (istyle && shdn_on && !cv_end
        |=> !alarm_q)
        else $error("shutdown did not clear interrupt");
    AST_CMP_HOLD: assert property (!istyle && alarm_q && !run_cont
        && !wr_evt |=> alarm_q)
        else $error("comparator alarm dropped in shutdown");
    AST_FQ_RISE: assert property (!istyle && $rose(alarm_q)
        |-> hi_q >= $past(need))
        else $error("alarm before fault count reached");
    AST_PIN: assert property ($past(alarm_q) && $past(setup_q[B_POL])
        |-> alert_out)
        else $error("pin level ignores polarity");

    COV_SINGLE: cover property (cv_end && single_q ##1 cv_q == CV_IDLE);
    COV_CMP: cover property (!istyle && $rose(alarm_q));
    COV_INT_RD: cover property (istyle && alarm_q ##1 rd_evt);

endmodule : temp_alarm

// ===== test/bus_host.sv
/*
 * Host model for the two-wire register port: start, stop, bytes
 * and whole register accesses, called by the bench.
 * Assumes the bench resolves the data wire with a pull-up.
 */
`timescale 1ns/10ps
module bus_host
    import alarm_pkg::*;
#(
    parameter logic [6:0] ADDR = 7'h2a, // Arbitrary bus address.
    parameter int         HALF = 32
)(
    input  wire logic sda,
    output logic      scl,
    output logic      sda_pull
);
    // ************************************************************
    // Bit and byte level
    // ************************************************************
    // Clock and data stand still and released between frames.
    initial
    begin
        scl      = 1'b1;
        sda_pull = 1'b0;
    end

    // Data moves only mid-way through the low phase of the clock.
    task automatic bit_io(input logic b, output logic r);
        #(HALF/2) sda_pull = ~b;
        #(HALF/2) scl = 1'b1;
        #(HALF-1) r = sda;
        #1 scl = 1'b0;
    endtask : bit_io

    task automatic start;
        #(HALF/2) sda_pull = 1'b0;
        #(HALF/2) scl = 1'b1;
        #(HALF/2) sda_pull = 1'b1;
        #(HALF/2) scl = 1'b0;
    endtask : start

    task automatic stop;
        #(HALF/2) sda_pull = 1'b1;
        #(HALF/2) scl = 1'b1;
        #(HALF/2) sda_pull = 1'b0;
    endtask : stop

    task automatic put_byte(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'b1, r);
    endtask : put_byte

    // The last byte of a read is refused so the device lets go.
    task automatic get_byte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(last, r);
    endtask : get_byte

    // ************************************************************
    // Register accesses
    // ************************************************************
    task automatic wr_setup(input logic [7:0] v);
        start();
        put_byte({ADDR, 1'b0});
        put_byte(PTR_SETUP);
        put_byte(v);
        stop();
    endtask : wr_setup

    task automatic wr_word(input logic [7:0] ptr, input logic [15:0] v);
        start();
        put_byte({ADDR, 1'b0});
        put_byte(ptr);
        put_byte(v[15:8]);
        put_byte(v[7:0]);
        stop();
    endtask : wr_word

    task automatic rd_word(input logic [7:0] ptr, output logic [15:0] v);
        start();
        put_byte({ADDR, 1'b0});
        put_byte(ptr);
        start();
        put_byte({ADDR, 1'b1});
        get_byte(1'b0, v[15:8]);
        get_byte(1'b1, v[7:0]);
        stop();
    endtask : rd_word
endmodule : bus_host

// ===== test/tb.sv
/*
 * Self-checking bench for the temperature alarm block.
 * Assumes the conversion period is shortened to CONV clocks.
 */
`timescale 1ns/10ps
module tb
    import alarm_pkg::*;
;
    // ************************************************************
    // Clock, reset, wiring
    // ************************************************************
    localparam int          CONV = 20;
    localparam logic [6:0]  DEV_ID = 7'h2a; // Arbitrary bus address.
    // Fractional readings T85 and T70 show how 12-bit and 9-bit resolution truncate.
    localparam logic [11:0] T85  = 12'h555;
    localparam logic [11:0] T77  = 12'h4d0;
    localparam logic [11:0] T70  = 12'h46f;
    localparam logic [11:0] T48  = 12'h300;
    logic        clk;
    logic        sys_rst;
    logic        scl;
    logic        sda;
    logic        sda_pull;
    logic        sda_out;
    logic        sda_oe_n;
    logic        alert_out;
    logic [11:0] temp_in;
    int          mismatches;
    int          total_checks;
    int          cycles;

    // Pull-up: the wire is low only while someone pulls it.
    assign sda = ~(sda_pull | (~sda_oe_n & ~sda_out));

    always #12.5 clk = ~clk;

    temp_alarm #(
        .DEV_ADDR (DEV_ID),
        .CONV_CYC (CONV)
    ) DUT (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .scl_in    (scl),
        .sda_in    (sda),
        .temp_in   (temp_in),
        .sda_out   (sda_out),
        .sda_oe_n  (sda_oe_n),
        .alert_out (alert_out)
    );

    bus_host #(
        .ADDR (DEV_ID)
    ) host (
        .sda      (sda),
        .scl      (scl),
        .sda_pull (sda_pull)
    );

    // ************************************************************
    // Helpers
    // ************************************************************
    task automatic report_and_stop;
        if (mismatches == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : report_and_stop

    // A hung wait must still end in the verdict.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic set_temp(input logic [11:0] t);
        @(negedge clk);
        temp_in = t;
    endtask : set_temp

    task automatic wait_alert(input logic lvl, output int n);
        n = 0;
        while (alert_out !== lvl && n < 400)
        begin
            @(negedge clk);
            n++;
        end
    endtask : wait_alert

    task automatic check_span(input int n, input int lo, input int hi);
        check({15'h0, (n >= lo && n <= hi)}, 16'h0001);
    endtask : check_span

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset_and_limits;
        logic [15:0] w;
        host.rd_word(PTR_SETUP, w);
        check(w, {SETUP_RST, 8'h00});
        host.rd_word(PTR_LOWER, w);
        check(w, LOWER_RST);
        host.rd_word(PTR_UPPER, w);
        check(w, UPPER_RST);
        host.wr_word(PTR_UPPER, 16'h50ff);
        host.rd_word(PTR_UPPER, w);
        check(w, 16'h5080);
        host.wr_word(PTR_UPPER, 16'h5000);
        host.wr_word(PTR_LOWER, 16'h4b00);
    endtask : t_reset_and_limits

    task automatic t_comparator;
        logic [15:0] w;
        int          n;
        set_temp(T85);
        wait_alert(1'b0, n);
        check({15'h0, alert_out}, 16'h0000);
        set_temp(T77);
        repeat (3 * CONV) @(negedge clk);
        check({15'h0, alert_out}, 16'h0000);
        host.wr_setup(8'h01);
        set_temp(T70);
        repeat (4 * CONV) @(negedge clk);
        check({15'h0, alert_out}, 16'h0000);
        host.rd_word(PTR_AMBIENT, w);
        check(w, 16'h4d00);
        host.wr_word(PTR_LOWER, 16'h4a00);
        host.rd_word(PTR_LOWER, w);
        check(w, 16'h4a00);
        host.wr_word(PTR_LOWER, 16'h4b00);
        host.wr_setup(8'h00);
        wait_alert(1'b1, n);
        check({15'h0, alert_out}, 16'h0001);
        host.wr_setup(8'h04);
        repeat (4) @(negedge clk);
        check({15'h0, alert_out}, 16'h0000);
        set_temp(T85);
        wait_alert(1'b1, n);
        check({15'h0, alert_out}, 16'h0001);
        host.wr_setup(8'h00);
        set_temp(T70);
        wait_alert(1'b1, n);
        check({15'h0, alert_out}, 16'h0001);
    endtask : t_comparator

    task automatic t_single;
        logic [15:0] w;
        int          n;
        host.wr_setup(8'h61);
        set_temp(T85);
        repeat (400) @(negedge clk);
        check({15'h0, alert_out}, 16'h0001);
        host.wr_setup(8'he1);
        wait_alert(1'b0, n);
        check_span(n, 8 * CONV - 30, 8 * CONV + 10);
        host.rd_word(PTR_SETUP, w);
        check(w, 16'h6100);
        host.rd_word(PTR_AMBIENT, w);
        check(w, 16'h5550);
        set_temp(T48);
        repeat (400) @(negedge clk);
        host.rd_word(PTR_AMBIENT, w);
        check(w, 16'h5550);
        host.wr_setup(8'h80);
        set_temp(T70);
        wait_alert(1'b1, n);
        check({15'h0, alert_out}, 16'h0001);
        host.rd_word(PTR_AMBIENT, w);
        check(w, 16'h4680);
    endtask : t_single

    task automatic t_queue;
        int n;
        int need;
        for (int i = 0; i < 4; i++)
        begin
            need = int'(FQ_CNT[i]);
            host.wr_setup({3'b000, 2'(i), 3'b000});
            set_temp(T85);
            wait_alert(1'b0, n);
            set_temp(T70);
            wait_alert(1'b1, n);
            check_span(n, (need - 1) * CONV + 1, need * CONV + 3);
            set_temp(T85);
            wait_alert(1'b0, n);
            check_span(n, (need - 1) * CONV + 1, need * CONV + 3);
        end
    endtask : t_queue

    task automatic t_interrupt;
        logic [15:0] w;
        int          n;
        set_temp(T70);
        wait_alert(1'b1, n);
        host.wr_setup(8'h02);
        host.rd_word(PTR_SETUP, w);
        set_temp(T85);
        wait_alert(1'b0, n);
        check({15'h0, alert_out}, 16'h0000);
        repeat (3 * CONV) @(negedge clk);
        check({15'h0, alert_out}, 16'h0000);
        host.rd_word(PTR_AMBIENT, w);
        check({15'h0, alert_out}, 16'h0001);
        repeat (3 * CONV) @(negedge clk);
        check({15'h0, alert_out}, 16'h0001);
        set_temp(T70);
        wait_alert(1'b0, n);
        check({15'h0, alert_out}, 16'h0000);
        host.rd_word(PTR_UPPER, w);
        check({15'h0, alert_out}, 16'h0001);
        set_temp(T85);
        wait_alert(1'b0, n);
        host.wr_setup(8'h03);
        repeat (4) @(negedge clk);
        check({15'h0, alert_out}, 16'h0001);
    endtask : t_interrupt

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        clk          = 1'b0;
        sys_rst      = 1'b1;
        temp_in      = T70;
        mismatches   = 0;
        total_checks = 0;
        cycles       = 0;
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge clk);
        t_reset_and_limits();
        t_comparator();
        t_single();
        t_queue();
        t_interrupt();
        report_and_stop();
    end
endmodule : tb
